// >>> rtl/secd_cfg.svh
// Constants for the storage ECC interpretation, logging and diagnostic block
`ifndef SECD_CFG_SVH
`define SECD_CFG_SVH

// Word geometry
`define SECD_WORD_W      16
`define SECD_BYTE_W      8
`define SECD_SYN_W       5
`define SECD_CHK_W       10

// Data bits covered by each syndrome / check bit
`define SECD_COVER_S1    8'h57
`define SECD_COVER_S2    8'h3B
`define SECD_COVER_S3    8'hAD
`define SECD_COVER_S4    8'hCE
`define SECD_COVER_S5    8'hF0

// Log word field positions
`define SECD_LOG_ENTRY   0
`define SECD_LOG_SYN_LO  1
`define SECD_LOG_SYN_HI  10
`define SECD_LOG_SPARE   11
`define SECD_LOG_BRD_LO  12
`define SECD_LOG_BRD_HI  15
`define SECD_LOG_RESET   16'h0000

`endif

// >>> rtl/secd_pkg.sv
// Types shared by the storage ECC block
package secd_pkg;
   // Diagnostic path selection
   typedef enum logic [1:0] {
      SECD_SEL_DATA,
      SECD_SEL_LOG,
      SECD_SEL_GEN,
      SECD_SEL_STORED
   } secd_sel_t;

   typedef logic [15:0] secd_word_t;
endpackage : secd_pkg

// >>> rtl/secd_log_if.sv
// Connection between the ECC core and its error log register
`timescale 1ns/1ps
interface secd_log_if;
   logic        load;
   logic        entry_clear;
   logic [15:0] capture;
   logic [15:0] word;

   modport core  (output load, output entry_clear, output capture, input word);
   modport store (input load, input entry_clear, input capture, output word);
endinterface : secd_log_if

// >>> rtl/secd_log_reg.sv
// Error log register with sticky new-entry bit
`timescale 1ns/1ps
`include "secd_cfg.svh"
module secd_log_reg
   import secd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Core side
   secd_log_if.store lg
);

   logic [15:1] log_body;
   logic        entry_bit;

   // Fields load only while the strobe is high, otherwise hold
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         log_body <= 15'h0000;
      end else if (lg.load) begin
         log_body <= lg.capture[15:1];
      end
   end

   // New-entry bit; a new load beats a simultaneous clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         entry_bit <= 1'b0;
      end else if (lg.load) begin
         entry_bit <= 1'b1;
      end else if (lg.entry_clear) begin
         entry_bit <= 1'b0;
      end
   end

   // Entry bit sits at the bottom of the log word
   assign lg.word = {log_body, entry_bit};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_log_entry_set: assert property (lg.load |=> entry_bit && log_body == $past(lg.capture[15:1]))
      else $error("log did not take a new entry");
   chk_log_hold_val: assert property (!lg.load |=> $stable(log_body))
      else $error("log changed without load strobe");
endmodule : secd_log_reg

// >>> rtl/secd_top.sv
// Storage ECC error interpretation, correction, logging and diagnostic select
`timescale 1ns/1ps
`include "secd_cfg.svh"

// Behaviour
// - All syndromes zero: good word, no fix flag, no error, no toggles.
// - One or three active syndromes in a byte: fix flag high, uncorrectable line low unless the other byte has two, four or five.
// - Two, four or five active: both uncorrectable line and fix flag high.
// - Check bit fails with lone syndrome; data bit by its three-syndrome AND.
// - Uncorrectable words still toggle decoded bits; five active inverts all eight.
// - Fix flag enables write-back so the corrected word is rewritten.
// - Any nonzero syndrome loads log with ten syndromes and four board bits.
// - Each new entry sets the entry bit; the processor clears it on inspection.
// - Every recognised error overwrites the log; it holds the latest one.
// - Log captures only while its load strobe is high, else holds.
// - Log layout: entry bit 0, syndromes 1-10, spare 11, board 12-15.
// - Correction is combinational; the processor data output is registered.
// - Each bit corrected from true and complement with corrector lines.
// - Corrected check bits go back to storage; corrected data to both.
// - Select lines decoded only while diagnostic request is active.
// - Any non-data select code suppresses all correction.
// - Generated-check code presents ten check bits made from write data.
// - Code 11 presents ten uncorrected stored check bits.
// - Check bits are even parity over their assigned data bits.
// - Syndrome is parity of stored check and its data bits.
// - Codes 00/01/10/11 pass data, log, generated, stored checks.
// - Entry bit clears when the log-read code is removed.
module secd_top
   import secd_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Word from the storage holding register
   input  wire logic [15:0] stored_data,
   input  wire logic [9:0]  stored_check,
   // Write data from the processor, for check generation
   input  wire logic [15:0] write_data,
   // Log capture inputs
   input  wire logic [3:0]  board_select,
   input  wire logic        log_load_strobe,
   // Diagnostic selection from processor control timing
   input  wire logic        diag_request_line,
   input  wire logic        diag_select_high,
   input  wire logic        diag_select_low,
   // Processor side
   output logic [15:0]      cpu_data,
   output logic             correctable_fix_flag,
   output logic             uncorrectable_error,
   // Storage write-back side
   output logic [15:0]      corrected_data,
   output logic [9:0]       corrected_check,
   output logic [1:0]       writeback_enable,
   output logic [9:0]       generated_check_code
);

   // Coverage mask of one syndrome row
   function automatic logic [7:0] cover_mask(input int unsigned j);
      case (j)
         0:       cover_mask = `SECD_COVER_S1;
         1:       cover_mask = `SECD_COVER_S2;
         2:       cover_mask = `SECD_COVER_S3;
         3:       cover_mask = `SECD_COVER_S4;
         default: cover_mask = `SECD_COVER_S5;
      endcase
   endfunction : cover_mask

   // Even parity check bits over a byte
   function automatic logic [4:0] gen_check(input logic [7:0] d);
      logic [4:0] c;
      c = 5'h00;
      for (int j = 0; j < 5; j++) begin
         c[j] = ^(d & cover_mask(j));
      end
      return c;
   endfunction : gen_check

   // Syndrome of a stored byte and its check bits
   function automatic logic [4:0] syndrome(input logic [7:0] d, input logic [4:0] c);
      return gen_check(d) ^ c;
   endfunction : syndrome

   // Data bit toggles: a bit flips only when every covering syndrome is active
   function automatic logic [7:0] data_toggle(input logic [4:0] s);
      logic [7:0] t;
      logic [7:0] m;
      t = 8'hFF;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 5; j++) begin
            m = cover_mask(j);
            if (m[i] && !s[j]) begin
               t[i] = 1'b0;
            end
         end
      end
      return t;
   endfunction : data_toggle

   // Check bit toggles: exactly one syndrome active
   function automatic logic [4:0] check_toggle(input logic [4:0] s);
      logic [4:0] t;
      t = 5'h00;
      for (int j = 0; j < 5; j++) begin
         t[j] = s[j] && ((s & ~(5'h01 << j)) == 5'h00);
      end
      return t;
   endfunction : check_toggle

   // Number of active syndromes
   function automatic logic [2:0] ones(input logic [4:0] s);
      logic [2:0] n;
      n = 3'h0;
      for (int j = 0; j < 5; j++) begin
         n = n + {2'b00, s[j]};
      end
      return n;
   endfunction : ones

   // Place ten check bits on the processor data lines, spares zero
   function automatic logic [15:0] place_check(input logic [9:0] c);
      return {3'b000, c[9:5], 3'b000, c[4:0]};
   endfunction : place_check

   secd_log_if lg ();

   secd_sel_t   sel;
   logic [9:0]  syn;
   logic [1:0]  byte_fix;
   logic [1:0]  byte_bad;
   logic [15:0] data_corr;
   logic [9:0]  check_corr;
   logic        log_sel_prev;
   secd_word_t  next_cpu_data;

   // Select decode; idle request means the normal data path
   always_comb begin
      if (!diag_request_line) begin
         sel = SECD_SEL_DATA;
      end else begin
         case ({diag_select_high, diag_select_low})
            2'b00:   sel = SECD_SEL_DATA;
            2'b01:   sel = SECD_SEL_LOG;
            2'b10:   sel = SECD_SEL_GEN;
            default: sel = SECD_SEL_STORED;
         endcase
      end
   end

   // Per-byte syndrome and classification
   always_comb begin
      syn        = 10'h000;
      byte_fix   = 2'b00;
      byte_bad   = 2'b00;
      data_corr  = 16'h0000;
      check_corr = 10'h000;
      for (int b = 0; b < 2; b++) begin
         syn[b*5 +: 5] = syndrome(stored_data[b*8 +: 8], stored_check[b*5 +: 5]);
         byte_fix[b]   = |syn[b*5 +: 5];
         byte_bad[b]   = ones(syn[b*5 +: 5]) inside {3'd2, 3'd4, 3'd5};
         // Diagnostic codes block the corrector lines entirely
         if (sel == SECD_SEL_DATA) begin
            data_corr[b*8 +: 8]  = data_toggle(syn[b*5 +: 5]);
            check_corr[b*5 +: 5] = check_toggle(syn[b*5 +: 5]);
         end
      end
   end

   // Word flags from both bytes
   assign correctable_fix_flag = |byte_fix;
   assign uncorrectable_error  = |byte_bad;

   // True and complement combined with the corrector lines, no clock involved
   assign corrected_data  = (stored_data & ~data_corr) | (~stored_data & data_corr);
   assign corrected_check = (stored_check & ~check_corr) | (~stored_check & check_corr);

   // Per-byte write-back timing enable
   assign writeback_enable = byte_fix;

   // Fresh check bits for the incoming write data
   assign generated_check_code = {gen_check(write_data[15:8]), gen_check(write_data[7:0])};

   // Log capture on any error while the strobe is high
   assign lg.load    = log_load_strobe && (|syn);
   // Extra select at bit 12, then bits a, b, c upward
   assign lg.capture = {board_select, 1'b0, syn, 1'b0};
   assign lg.entry_clear = log_sel_prev && (sel != SECD_SEL_LOG);

   // Remember log selection to see its removal
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         log_sel_prev <= 1'b0;
      end else begin
         log_sel_prev <= (sel == SECD_SEL_LOG);
      end
   end

   secd_log_reg u_log (
      .clk     (clk),
      .reset_n (reset_n),
      .lg      (lg.store)
   );

   // Processor data selection
   always_comb begin
      case (sel)
         SECD_SEL_DATA:   next_cpu_data = corrected_data;
         SECD_SEL_LOG:    next_cpu_data = lg.word;
         SECD_SEL_GEN:    next_cpu_data = place_check(generated_check_code);
         SECD_SEL_STORED: next_cpu_data = place_check(stored_check);
         default:         next_cpu_data = corrected_data;
      endcase
   end

   // Registered so the processor sees a clean word; adds one cycle of latency
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_data <= 16'h0000;
      end else begin
         cpu_data <= next_cpu_data;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_gen_sel;
      sel == SECD_SEL_GEN;
   endsequence

   sequence s_stored_sel;
      sel == SECD_SEL_STORED;
   endsequence

   chk_good_word_quiet: assert property (syn == 10'h000 |-> !correctable_fix_flag && !uncorrectable_error && data_corr == 16'h0000)
      else $error("good word raised a flag or toggle");
   chk_single_fix_ok: assert property (ones(syn[4:0]) inside {3'd1, 3'd3} && ones(syn[9:5]) inside {3'd0, 3'd1, 3'd3} |-> correctable_fix_flag && !uncorrectable_error)
      else $error("correctable word misclassified");
   chk_bad_both_high: assert property (ones(syn[4:0]) inside {3'd2, 3'd4, 3'd5} |-> uncorrectable_error && correctable_fix_flag)
      else $error("uncorrectable byte not reported");
   chk_all_five_inv: assert property (syn[4:0] == 5'h1F && sel == SECD_SEL_DATA |-> corrected_data[7:0] == ~stored_data[7:0])
      else $error("five syndromes did not invert byte");
   chk_suppress_corr: assert property (sel != SECD_SEL_DATA |-> corrected_data == stored_data && corrected_check == stored_check)
      else $error("correction active under diagnostic code");
   chk_wb_follows_fix: assert property (writeback_enable != 2'b00 |-> correctable_fix_flag)
      else $error("write-back without fix flag");
   chk_log_captures: assert property (lg.load |=> lg.word[10:1] == $past(syn) && lg.word[0] && lg.word[11] == 1'b0)
      else $error("log missed syndromes");
   chk_entry_clears: assert property (sel == SECD_SEL_LOG ##1 sel != SECD_SEL_LOG && !lg.load |=> !lg.word[0])
      else $error("entry bit not cleared after log read");
   chk_gen_out: assert property (s_gen_sel |=> cpu_data == place_check($past(generated_check_code)))
      else $error("generated check bits not presented");
   chk_stored_out: assert property (s_stored_sel |=> cpu_data == place_check($past(stored_check)))
      else $error("stored check bits not presented");
   chk_req_gates_sel: assert property (!diag_request_line |=> cpu_data == $past(corrected_data))
      else $error("select decoded without request");
endmodule : secd_top

// >>> bench/secd_cpu_model.sv
// Processor control timing model driving diagnostic select and log strobe
`timescale 1ns/1ps
module secd_cpu_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Commands from the bench
   input  wire logic       cmd_req,
   input  wire logic [1:0] cmd_code,
   input  wire logic       cmd_load,
   // Lines toward the storage block
   output logic            diag_request_line,
   output logic            diag_select_high,
   output logic            diag_select_low,
   output logic            log_load_strobe
);
   // Request and code move at one edge, so no half code is ever seen
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         diag_request_line <= 1'b0;
         diag_select_high  <= 1'b0;
         diag_select_low   <= 1'b0;
      end else begin
         diag_request_line <= cmd_req;
         // Leaving the log code is how an inspection retires the entry bit
         {diag_select_high, diag_select_low} <= cmd_code;
      end
   end

   // Strobe lasts one cycle per command
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         log_load_strobe <= 1'b0;
      else
         log_load_strobe <= cmd_load;
   end
endmodule : secd_cpu_model

// >>> bench/test_secd_top.sv
// Self-checking bench for the storage ECC interpretation block
`timescale 1ns/1ps
module test_secd_top
   import secd_pkg::*;
;
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] dflip;
      logic [9:0]  cflip;
      logic        fix;
      logic        bad;
   } secd_row_t;
   // Clean, single, double, four and five syndrome cases
   localparam secd_row_t ROWS [11] = '{
      '{16'h0000, 16'h0000, 10'h000, 1'b0, 1'b0}, '{16'hA5C3, 16'h0000, 10'h000, 1'b0, 1'b0},
      '{16'h1234, 16'h0001, 10'h000, 1'b1, 1'b0}, '{16'h1234, 16'h8000, 10'h000, 1'b1, 1'b0},
      '{16'hFFFF, 16'h0000, 10'h001, 1'b1, 1'b0}, '{16'h0F0F, 16'h0000, 10'h200, 1'b1, 1'b0},
      '{16'h00FF, 16'h0003, 10'h000, 1'b1, 1'b1}, '{16'hC33C, 16'h0000, 10'h00F, 1'b1, 1'b1},
      '{16'h5A5A, 16'h0000, 10'h01F, 1'b1, 1'b1}, '{16'h7E81, 16'h0100, 10'h001, 1'b1, 1'b0},
      '{16'h6699, 16'h0001, 10'h060, 1'b1, 1'b1}};
   localparam logic [7:0] MSK [5] = '{8'h57, 8'h3B, 8'hAD, 8'hCE, 8'hF0};
   logic        clk, reset_n, cmd_req, cmd_load, log_load_strobe;
   logic        diag_request_line, diag_select_high, diag_select_low;
   logic        correctable_fix_flag, uncorrectable_error;
   logic [1:0]  cmd_code, writeback_enable;
   logic [3:0]  board_select;
   logic [15:0] stored_data, write_data, cpu_data, corrected_data, sd, expd, explog;
   logic [9:0]  stored_check, corrected_check, generated_check_code, sc, syn, expc;
   int          errors, checked;

   secd_top i_secd_top (.clk, .reset_n, .stored_data, .stored_check, .write_data,
      .board_select, .log_load_strobe, .diag_request_line, .diag_select_high,
      .diag_select_low, .cpu_data, .correctable_fix_flag, .uncorrectable_error,
      .corrected_data, .corrected_check, .writeback_enable, .generated_check_code);
   secd_cpu_model i_secd_cpu_model (.clk, .reset_n, .cmd_req, .cmd_code, .cmd_load,
      .diag_request_line, .diag_select_high, .diag_select_low, .log_load_strobe);

   // Even parity per check bit over its covered data bits
   function automatic logic [4:0] gen5(input logic [7:0] d);
      for (int j = 0; j < 5; j++)
         gen5[j] = ^(d & MSK[j]);
   endfunction : gen5

   function automatic logic [9:0] gen10(input logic [15:0] w);
      gen10 = {gen5(w[15:8]), gen5(w[7:0])};
   endfunction : gen10

   // Check bits as laid on the processor lines, spares zero
   function automatic logic [15:0] plc(input logic [9:0] c);
      plc = {3'b000, c[9:5], 3'b000, c[4:0]};
   endfunction : plc

   // Toggle each data bit whose three syndromes are all active
   function automatic logic [12:0] fixb(input logic [7:0] d, input logic [4:0] c);
      logic [4:0] s;
      logic       f;
      s = gen5(d) ^ c;
      for (int i = 0; i < 8; i++) begin
         f = 1'b1;
         for (int j = 0; j < 5; j++)
            if (MSK[j][i])
               f &= s[j];
         d[i] ^= f;
      end
      if ($countones(s) == 1)
         c ^= s;
      fixb = {c, d};
   endfunction : fixb

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Command the partner, then let lines and the output register settle
   task automatic ctl(input logic req, input logic [1:0] code, input logic ld);
      @(posedge clk);
      cmd_req  <= req;
      cmd_code <= code;
      cmd_load <= ld;
      @(posedge clk);
      cmd_load <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : ctl

   task automatic final_report;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Fixed bound, far above the run length
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      final_report();
   end

   initial begin
      errors = 0; checked = 0; reset_n = 1'b0; cmd_req = 1'b0; cmd_code = 2'b00;
      cmd_load = 1'b0; stored_data = '0; stored_check = '0; write_data = '0;
      board_select = '0; explog = '0;
      repeat (10) @(posedge clk);
      check("cpu in reset", cpu_data, 16'h0000);
      reset_n <= 1'b1;
      ctl(1'b1, 2'b01, 1'b0);
      check("log after reset", cpu_data, 16'h0000);
      foreach (ROWS[i]) begin
         sd = ROWS[i].data ^ ROWS[i].dflip;
         sc = gen10(ROWS[i].data) ^ ROWS[i].cflip;
         syn = gen10(sd) ^ sc;
         {expc[4:0], expd[7:0]} = fixb(sd[7:0], sc[4:0]);
         {expc[9:5], expd[15:8]} = fixb(sd[15:8], sc[9:5]);
         stored_data <= sd;
         stored_check <= sc;
         write_data <= ROWS[i].data;
         board_select <= 4'(i);
         ctl(1'b0, 2'b00, 1'b1);
         check("fix", 16'(correctable_fix_flag), 16'(ROWS[i].fix));
         check("bad", 16'(uncorrectable_error), 16'(ROWS[i].bad));
         check("wben", 16'(writeback_enable), {14'h0, |syn[9:5], |syn[4:0]});
         check("data", corrected_data, expd);
         check("chk", 16'(corrected_check), 16'(expc));
         check("cpu", cpu_data, expd);
         check("gen", 16'(generated_check_code), 16'(gen10(ROWS[i].data)));
         explog = ROWS[i].fix ? {4'(i), 1'b0, syn, 1'b1} : {explog[15:1], 1'b0};
         ctl(1'b1, 2'b01, 1'b0);
         check("log", cpu_data, explog);
      end
      // Every select code with a correctable fault and no strobe
      sd = 16'h1235;
      sc = gen10(16'h1234);
      stored_data <= sd;
      stored_check <= sc;
      write_data <= 16'h5AF0;
      for (int k = 0; k < 4; k++) begin
         ctl(1'b1, 2'(k), 1'b0);
         explog[0] = 1'b0;
         check("sel", cpu_data, k == 0 ? 16'h1234 : k == 1 ? explog : k == 2 ?
            plc(gen10(16'h5AF0)) : plc(sc));
         check("sel data", corrected_data, k == 0 ? 16'h1234 : sd);
         check("sel chk", 16'(corrected_check), 16'(sc));
      end
      ctl(1'b0, 2'b11, 1'b0);
      check("no request", cpu_data, 16'h1234);
      // Mid-run reset must empty a log that still holds syndromes
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("cpu mid reset", cpu_data, 16'h0000);
      @(posedge clk);
      reset_n <= 1'b1;
      ctl(1'b1, 2'b01, 1'b0);
      check("log mid reset", cpu_data, 16'h0000);
      final_report();
   end
endmodule : test_secd_top
